// ==== basic_update_timer_tb.sv ====
/* Self-checking bench for the basic update timer.
   Assumes one 20 MHz clock and the bench as sole APB master. */
`timescale 1ns/1ps
`default_nettype none
`include "but_map.vh"
module basic_update_timer_tb;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic PREADY, PSLVERR, UPDATE_IRQ, UPDATE_DMA_REQ;
    logic [31:0] PRDATA;
    logic [31:0] rd; // Last read data
    logic err; // Last slave error
    logic [31:0] v; // Random value
    int failures = 0;
    int tests_run = 0;
    int n, p, a;
    logic [7:0] adr [7] = '{8'h0C, 8'h10, 8'h14, 8'h24, 8'h28, 8'h2C, 8'h04};
    logic [31:0] rst [7] = '{0, 0, 0, 0, 0, 32'hFFFF, 0};
    // ------------------------------------------------
    // Clock and design
    // ------------------------------------------------
    always #25 CLK = ~CLK;
    but_timer u_but_timer (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
        .UPDATE_IRQ(UPDATE_IRQ), .UPDATE_DMA_REQ(UPDATE_DMA_REQ));
    // ------------------------------------------------
    // Shared tasks
    // ------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer; request held until pready is sampled
    task automatic xfer(input logic w, input logic [7:0] ad,
        input logic [31:0] d = 32'h0);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // Cycles to next dma pulse; 600 means none came
    task automatic wait_dma(output int c);
        c = 0;
        do begin
            @(posedge CLK);
            c++;
        end while (UPDATE_DMA_REQ !== 1'b1 && c < 600);
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ------------------------------------------------
    // Watchdog, far beyond the few thousand cycles used
    // ------------------------------------------------
    initial begin
        #(50 * 20000);
        failures++;
        tally_and_finish();
    end
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        v = $urandom(32'hE2B0E0C4);
        repeat (3) @(posedge CLK);
        RESET_N <= 1'b1;
        foreach (adr[i]) begin
            xfer(1'b0, adr[i]);
            check("reset value", rd, rst[i]);
            check("slave error", err, i == 6);
        end
        xfer(1'b1, 8'h04, 32'h1);
        check("write error", err, 1'b1);
        // Random readback of plain registers, reserved bits kept zero
        repeat (4) begin
            v = $urandom & 32'hFFFF;
            foreach (adr[i]) if (i > 2 && i < 6) begin
                xfer(1'b1, adr[i], v);
                xfer(1'b0, adr[i]);
                check("readback", rd, v);
            end
            xfer(1'b1, `BUT_OFF_DIEN, v & 32'h101);
            xfer(1'b0, `BUT_OFF_DIEN);
            check("enable readback", rd, v & 32'h101);
        end
        // Forced update with both enables, counter stopped
        xfer(1'b1, `BUT_OFF_DIEN, 32'h101);
        xfer(1'b1, `BUT_OFF_CNT, 32'h5);
        xfer(1'b1, `BUT_OFF_EVG, 32'h0);
        xfer(1'b0, `BUT_OFF_STS);
        check("flag after zero", rd, 32'h0);
        xfer(1'b1, `BUT_OFF_EVG, 32'h1);
        xfer(1'b0, `BUT_OFF_STS);
        check("flag after force", rd, 32'h1);
        xfer(1'b0, `BUT_OFF_CNT);
        check("count after force", rd, 32'h0);
        xfer(1'b0, `BUT_OFF_EVG);
        check("force bit", rd, 32'h0);
        check("irq set", UPDATE_IRQ, 1'b1);
        xfer(1'b1, `BUT_OFF_STS, 32'h1);
        xfer(1'b0, `BUT_OFF_STS);
        check("flag kept", rd, 32'h1);
        xfer(1'b1, `BUT_OFF_STS, 32'h0);
        xfer(1'b0, `BUT_OFF_STS);
        check("flag cleared", rd, 32'h0);
        check("irq cleared", UPDATE_IRQ, 1'b0);
        // Source select, then update disable: no flag, counter restarts
        for (int m = 4; m > 1; m -= 2) begin
            xfer(1'b1, `BUT_OFF_CTRL, m);
            xfer(1'b1, `BUT_OFF_CNT, 32'h7);
            xfer(1'b1, `BUT_OFF_EVG, 32'h1);
            xfer(1'b0, `BUT_OFF_STS);
            check("flag masked", rd, 32'h0);
            xfer(1'b0, `BUT_OFF_CNT);
            check("count reinit", rd, 32'h0);
        end
        // Period of overflow, smallest case first
        for (int k = 0; k < 4; k++) begin
            p = k ? $urandom_range(3) : 0;
            a = k ? $urandom_range(6, 1) : 1;
            xfer(1'b1, `BUT_OFF_CTRL, k == 3 ? 32'h80 : 32'h0);
            xfer(1'b1, `BUT_OFF_PSC, p);
            xfer(1'b1, `BUT_OFF_ARR, a);
            if (k < 3) xfer(1'b1, `BUT_OFF_EVG, 32'h1);
            xfer(1'b1, `BUT_OFF_CTRL, k == 3 ? 32'h81 : 32'h1);
            wait_dma(n);
            wait_dma(n);
            check("period", n, (p + 1) * (a + 1));
            xfer(1'b0, `BUT_OFF_STS);
            check("overflow flag", rd, 32'h1);
        end
        // Single pulse stops after one update
        xfer(1'b1, `BUT_OFF_CTRL, 32'h9);
        wait_dma(n);
        xfer(1'b0, `BUT_OFF_CTRL);
        check("single pulse", rd, 32'h8);
        wait_dma(n);
        check("no further update", n, 600);
        // Zero reload holds the counter
        xfer(1'b1, `BUT_OFF_CTRL, 32'h0);
        xfer(1'b1, `BUT_OFF_ARR, 32'h0);
        xfer(1'b1, `BUT_OFF_CNT, 32'h0);
        xfer(1'b1, `BUT_OFF_CTRL, 32'h1);
        wait_dma(n);
        check("zero reload", n, 600);
        xfer(1'b0, `BUT_OFF_CNT);
        check("count held", rd, 32'h0);
        // Interrupt only: flag rises, no dma
        xfer(1'b1, `BUT_OFF_STS, 32'h0);
        xfer(1'b1, `BUT_OFF_DIEN, 32'h1);
        xfer(1'b1, `BUT_OFF_ARR, 32'h1);
        wait_dma(n);
        check("dma disabled", n, 600);
        check("irq level", UPDATE_IRQ, 1'b1);
        xfer(1'b1, `BUT_OFF_DIEN, 32'h0);
        xfer(1'b0, `BUT_OFF_STS);
        check("irq masked", UPDATE_IRQ, 1'b0);
        tally_and_finish();
    end
endmodule // basic_update_timer_tb
`default_nettype wire

// ==== but_map.vh ====
/*
 * Register map, field positions, reset values for the basic update timer.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
`ifndef BUT_MAP_VH
`define BUT_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define BUT_OFF_CTRL 8'h00
`define BUT_OFF_DIEN 8'h0C
`define BUT_OFF_STS 8'h10
`define BUT_OFF_EVG 8'h14
`define BUT_OFF_CNT 8'h24
`define BUT_OFF_PSC 8'h28
`define BUT_OFF_ARR 8'h2C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BUT_CTRL_EN 0
`define BUT_CTRL_UDIS 1
`define BUT_CTRL_USRC 2
`define BUT_CTRL_SPM 3
`define BUT_CTRL_ARPE 7
`define BUT_DIEN_IRQ 0
`define BUT_DIEN_DMA 8
`define BUT_STS_UF 0
`define BUT_EVG_FU 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BUT_RST_CTRL 16'h0000
`define BUT_RST_DIEN 16'h0000
`define BUT_RST_CNT 16'h0000
`define BUT_RST_PSC 16'h0000
`define BUT_RST_ARR 16'hFFFF

`endif

// ==== but_prescaler.v ====
/*
 * Prescaler divider for the basic update timer.
 * Assumes the divisor comes from the active shadow and restart is a pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module but_prescaler #(
    parameter WIDTH = 16
) (
    input wire clk,
    input wire reset_n,
    input wire [WIDTH-1:0] divisor,
    input wire restart,
    output wire tick
);

    // ------------------------------------------------------------
    // Divider counter
    // ------------------------------------------------------------
    reg [WIDTH-1:0] div_cnt_r; // Internal prescaler count
    reg [WIDTH-1:0] div_cnt_nxt; // Next count

    // Tick when the count has reached the divisor: rate clk/(div+1)
    assign tick = (div_cnt_r == divisor) && !restart;

    // Next-count logic, restart has priority
    always @* begin
        if (restart) begin
            div_cnt_nxt = {WIDTH{1'b0}};
        end else if (div_cnt_r >= divisor) begin
            div_cnt_nxt = {WIDTH{1'b0}}; // Wrap
        end else begin
            div_cnt_nxt = div_cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Counter register
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt_r <= {WIDTH{1'b0}};
        end else begin
            div_cnt_r <= div_cnt_nxt;
        end
    end

endmodule // but_prescaler

`default_nettype wire

// ==== but_timer.v ====
/*
 * Basic 16-bit up-counting update timer with APB register access.
 * Assumes a single clock, APB master per AMBA rules, DMA/IRQ sinks outside.
 */
// Implementation choice: the APB register port.
//
// Behaviour
// - DMA request on update only when enabled
// - Update interrupt only while its enable set
// - Overflow sets flag unless updates disabled
// - Forced update sets flag if source/disable zero
// - Flag cleared by writing zero only
// - Force bit write-only, self-clearing, zero ignored
// - Force restarts counter, prescaler; loads shadows unless updates disabled
// - Prescaler value takes effect at update
// - Counter clock is input over prescaler+1
// - Reload value feeds active reload register
// - Zero reload stops counting
// - Source select one: only overflow requests
// - Update disable: no event, force reinits
// - Preload enable buffers reload until update
// - Single pulse clears enable at update
`timescale 1ns/1ps
`default_nettype none
`include "but_map.vh"

module but_timer #(
    parameter WIDTH = 16
) (
    input wire CLK,
    input wire RESET_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output wire PREADY,
    output reg [31:0] PRDATA,
    output wire PSLVERR,
    output reg UPDATE_IRQ,
    output reg UPDATE_DMA_REQ
);

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire acc = PSEL && PENABLE; // Access phase, always zero wait
    wire wr = acc && PWRITE; // Write takes effect here
    wire rd = acc && !PWRITE; // Read data sampled here
    wire hit_ctrl = (PADDR == `BUT_OFF_CTRL);
    wire hit_dien = (PADDR == `BUT_OFF_DIEN);
    wire hit_sts = (PADDR == `BUT_OFF_STS);
    wire hit_evg = (PADDR == `BUT_OFF_EVG);
    wire hit_cnt = (PADDR == `BUT_OFF_CNT);
    wire hit_psc = (PADDR == `BUT_OFF_PSC);
    wire hit_arr = (PADDR == `BUT_OFF_ARR);
    wire mapped = hit_ctrl || hit_dien || hit_sts || hit_evg ||
        hit_cnt || hit_psc || hit_arr;

    // Zero wait states; unmapped addresses answer with an error
    assign PREADY = 1'b1;
    assign PSLVERR = acc && !mapped;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg counter_enable_r; // Counter runs
    reg update_disable_r; // Blocks update events
    reg update_source_select_r; // Only overflow requests
    reg single_pulse_mode_r; // Stop at next update
    reg reload_preload_enable_r; // Buffer reload writes
    reg update_irq_enable_r; // Interrupt gate
    reg update_dma_enable_r; // DMA gate
    reg update_flag_r; // Sticky update flag
    reg force_update_r; // Force pulse, self-clearing
    reg [WIDTH-1:0] counter_value_r; // Main counter
    reg [WIDTH-1:0] prescaler_value_r; // Preload prescaler
    reg [WIDTH-1:0] prescaler_active_r; // Active prescaler
    reg [WIDTH-1:0] reload_value_r; // Preload reload
    reg [WIDTH-1:0] reload_active_r; // Active reload

    // ------------------------------------------------------------
    // Event logic
    // ------------------------------------------------------------
    wire presc_tick; // Prescaled counter clock
    wire count_step; // Counter advances this cycle
    wire overflow; // Counter at reload and steps
    wire ovf_event; // Overflow update event
    wire frc_event; // Forced update event
    wire update_event; // Any update event
    wire req_event; // Event allowed to request IRQ/DMA
    wire flag_set; // Hardware sets flag
    wire flag_clr; // Software clears flag

    // Count only with a nonzero reload and a prescaler tick
    assign count_step = counter_enable_r && presc_tick &&
        (reload_active_r != {WIDTH{1'b0}});
    assign overflow = count_step &&
        (counter_value_r >= reload_active_r);

    // Update events are suppressed while update_disable is set
    assign ovf_event = overflow && !update_disable_r;
    assign frc_event = force_update_r && !update_disable_r;
    assign update_event = ovf_event || frc_event;

    // Forced updates only flag/request when source select is zero
    assign req_event = ovf_event ||
        (frc_event && !update_source_select_r);
    assign flag_set = req_event;
    assign flag_clr = wr && hit_sts && !PWDATA[`BUT_STS_UF];

    // ------------------------------------------------------------
    // Prescaler instance
    // ------------------------------------------------------------
    // Force restarts the prescaler even with updates disabled
    but_prescaler #(
        .WIDTH(WIDTH)
    ) u_presc (
        .clk(CLK),
        .reset_n(RESET_N),
        .divisor(prescaler_active_r),
        .restart(force_update_r),
        .tick(presc_tick)
    );

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Single-pulse clears the enable at update; a same-cycle write of
    // the enable bit is overridden since hardware must stop.
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            counter_enable_r <= 1'b0;
            update_disable_r <= 1'b0;
            update_source_select_r <= 1'b0;
            single_pulse_mode_r <= 1'b0;
            reload_preload_enable_r <= 1'b0;
        end else begin
            if (wr && hit_ctrl) begin
                counter_enable_r <= PWDATA[`BUT_CTRL_EN];
                update_disable_r <= PWDATA[`BUT_CTRL_UDIS];
                update_source_select_r <= PWDATA[`BUT_CTRL_USRC];
                single_pulse_mode_r <= PWDATA[`BUT_CTRL_SPM];
                reload_preload_enable_r <= PWDATA[`BUT_CTRL_ARPE];
            end
            if (update_event && single_pulse_mode_r) begin
                counter_enable_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // DMA / interrupt enable register
    // ------------------------------------------------------------
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            update_irq_enable_r <= 1'b0;
            update_dma_enable_r <= 1'b0;
        end else if (wr && hit_dien) begin
            update_irq_enable_r <= PWDATA[`BUT_DIEN_IRQ];
            update_dma_enable_r <= PWDATA[`BUT_DIEN_DMA];
        end
    end

    // ------------------------------------------------------------
    // Status flag and force bit
    // ------------------------------------------------------------
    // Set wins over a same-cycle software clear
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            update_flag_r <= 1'b0;
        end else if (flag_set) begin
            update_flag_r <= 1'b1;
        end else if (flag_clr) begin
            update_flag_r <= 1'b0;
        end
    end

    // Force bit lives one cycle; writing zero does nothing
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            force_update_r <= 1'b0;
        end else begin
            force_update_r <= wr && hit_evg &&
                PWDATA[`BUT_EVG_FU];
        end
    end

    // ------------------------------------------------------------
    // Prescaler and reload preload / shadow registers
    // ------------------------------------------------------------
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prescaler_value_r <= `BUT_RST_PSC;
            prescaler_active_r <= `BUT_RST_PSC;
            reload_value_r <= `BUT_RST_ARR;
            reload_active_r <= `BUT_RST_ARR;
        end else begin
            if (wr && hit_psc) begin
                prescaler_value_r <= PWDATA[WIDTH-1:0];
            end
            if (wr && hit_arr) begin
                reload_value_r <= PWDATA[WIDTH-1:0];
            end
            // Shadows load at update; while disabled the prescaler shadow holds, reload only without preload
            if (update_event) begin
                prescaler_active_r <= prescaler_value_r;
                reload_active_r <= reload_value_r;
            end
            // Without preload the reload value acts at once
            if (!reload_preload_enable_r && wr && hit_arr) begin
                reload_active_r <= PWDATA[WIDTH-1:0];
            end else if (!reload_preload_enable_r && !update_event) begin
                reload_active_r <= reload_value_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Main counter
    // ------------------------------------------------------------
    // Force restart beats software write, which beats counting
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            counter_value_r <= `BUT_RST_CNT;
        end else if (force_update_r) begin
            counter_value_r <= {WIDTH{1'b0}};
        end else if (wr && hit_cnt) begin
            counter_value_r <= PWDATA[WIDTH-1:0];
        end else if (overflow) begin
            counter_value_r <= {WIDTH{1'b0}};
        end else if (count_step) begin
            counter_value_r <= counter_value_r +
                {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // ------------------------------------------------------------
    // Interrupt and DMA outputs
    // ------------------------------------------------------------
    // IRQ is a level following the flag; DMA is a one-cycle pulse
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            UPDATE_IRQ <= 1'b0;
            UPDATE_DMA_REQ <= 1'b0;
        end else begin
            UPDATE_IRQ <= update_irq_enable_r &&
                (update_flag_r || flag_set) && !flag_clr;
            UPDATE_DMA_REQ <= update_dma_enable_r && req_event;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Registered read data; force bit reads zero
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PRDATA <= 32'h00000000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= 32'h00000000;
            if (PADDR == `BUT_OFF_CTRL) begin
                PRDATA[`BUT_CTRL_EN] <= counter_enable_r;
                PRDATA[`BUT_CTRL_UDIS] <= update_disable_r;
                PRDATA[`BUT_CTRL_USRC] <= update_source_select_r;
                PRDATA[`BUT_CTRL_SPM] <= single_pulse_mode_r;
                PRDATA[`BUT_CTRL_ARPE] <= reload_preload_enable_r;
            end else if (PADDR == `BUT_OFF_DIEN) begin
                PRDATA[`BUT_DIEN_IRQ] <= update_irq_enable_r;
                PRDATA[`BUT_DIEN_DMA] <= update_dma_enable_r;
            end else if (PADDR == `BUT_OFF_STS) begin
                PRDATA[`BUT_STS_UF] <= update_flag_r;
            end else if (PADDR == `BUT_OFF_CNT) begin
                // Sampled in setup; value is one cycle old at access
                PRDATA[WIDTH-1:0] <= counter_value_r;
            end else if (PADDR == `BUT_OFF_PSC) begin
                PRDATA[WIDTH-1:0] <= prescaler_value_r;
            end else if (PADDR == `BUT_OFF_ARR) begin
                PRDATA[WIDTH-1:0] <= reload_value_r;
            end
        end
    end

    // Unused read strobe kept for clarity of decode intent
    wire unused_rd = rd;

endmodule // but_timer

`default_nettype wire

// ==== but_timer_assertions.sv ====
/* Port checker for the basic update timer.
   Assumes an APB master keeping the protocol; bound to but_timer. */
`timescale 1ns/1ps
`default_nettype none
module but_timer_chk (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic [31:0] PRDATA,
    input wire logic PSLVERR,
    input wire logic UPDATE_IRQ,
    input wire logic UPDATE_DMA_REQ
);
    // ------------------------------------------------
    // Shadow of what software wrote
    // ------------------------------------------------
    logic acc; // Access edge of a transfer
    logic wr; // Write taking effect
    logic unm; // Address outside the map
    logic fu; // Forced update requested
    logic irq_en_r; // Interrupt enable seen
    logic dma_en_r; // DMA enable seen
    logic [2:0] ctl_r; // Source, disable, run bits
    assign acc = PSEL && PENABLE && PREADY;
    assign wr = acc && PWRITE;
    assign unm = !(PADDR inside {8'h00, 8'h0C, 8'h10, 8'h14, 8'h24,
        8'h28, 8'h2C});
    assign fu = wr && PADDR == 8'h14 && PWDATA[0];
    // Run bit may be cleared by hardware; only used to exclude overflow
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_en_r <= 1'b0;
            dma_en_r <= 1'b0;
            ctl_r <= 3'h0;
        end else if (wr && PADDR == 8'h0C) begin
            irq_en_r <= PWDATA[0];
            dma_en_r <= PWDATA[8];
        end else if (wr && PADDR == 8'h00) begin
            ctl_r <= PWDATA[2:0];
        end
    end
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    AST_DMA_GATED: assert property (
        UPDATE_DMA_REQ |-> dma_en_r || $past(dma_en_r))
        else $error("dma request while disabled");
    AST_IRQ_GATED: assert property (
        UPDATE_IRQ |-> irq_en_r || $past(irq_en_r))
        else $error("interrupt while disabled");
    AST_FORCE_FLAG: assert property (
        fu && irq_en_r && ctl_r[2:1] == 2'b00 |-> ##[3:4] UPDATE_IRQ)
        else $error("forced update raised no interrupt");
    AST_FORCE_DMA: assert property (
        fu && dma_en_r && ctl_r[2:1] == 2'b00 |-> ##2 UPDATE_DMA_REQ)
        else $error("forced update raised no dma request");
    AST_SRC_NO_DMA: assert property (
        fu && ctl_r == 3'b100 |-> ##1 !UPDATE_DMA_REQ [*3])
        else $error("forced update requested with source select");
    AST_UDIS_QUIET: assert property (
        ctl_r[1] && $past(ctl_r[1], 3) |-> !UPDATE_DMA_REQ)
        else $error("update event while updates disabled");
    AST_DMA_PULSE: assert property (
        UPDATE_DMA_REQ |=> !UPDATE_DMA_REQ)
        else $error("dma request longer than one cycle");
    AST_CLEAR_FLAG: assert property (
        wr && PADDR == 8'h10 && !PWDATA[0] && !ctl_r[0] |-> ##2 !UPDATE_IRQ)
        else $error("flag not cleared by writing zero");
    AST_DEAD_READ: assert property (
        acc && !PWRITE && (unm || PADDR == 8'h14)
        |-> PRDATA == 32'h0 && PSLVERR == unm)
        else $error("write-only or unmapped read not zero");
    cover property (fu ##2 UPDATE_DMA_REQ);
    cover property (UPDATE_IRQ);
    cover property (acc && PSLVERR);
endmodule // but_timer_chk
bind but_timer but_timer_chk u_but_timer_chk (.CLK(CLK), .RESET_N(RESET_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .UPDATE_IRQ(UPDATE_IRQ), .UPDATE_DMA_REQ(UPDATE_DMA_REQ));
`default_nettype wire
